/* File: core/timer_pkg.sv */
// constants shared by the match/capture timer and its helpers
// assumes a word-aligned register port with 8-bit byte addresses
package timer_pkg;
	localparam int ADDR_W = 8;
	localparam int NUM_MATCH = 4;
	localparam int NUM_OUT = 2;
	localparam int NUM_EVT = 5;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_PRESC = 8'h08;
	localparam logic [7:0] OFF_PCOUNT = 8'h0c;
	localparam logic [7:0] OFF_MATCH0 = 8'h10;
	localparam logic [7:0] MATCH_SPAN = 8'h10;
	localparam logic [7:0] OFF_MCTRL = 8'h20;
	localparam logic [7:0] OFF_CAPVAL = 8'h24;
	localparam logic [7:0] OFF_CAPCFG = 8'h28;
	localparam logic [7:0] OFF_EXT = 8'h2c;
	localparam logic [7:0] OFF_STAT = 8'h30;
	localparam logic [7:0] OFF_CLR = 8'h34;
	localparam logic [7:0] OFF_IEN = 8'h38;
	// field positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_HOLD = 1;
	localparam int CAP_RISE = 0;
	localparam int CAP_FALL = 1;
	localparam int EXT_PWM = 4;
	localparam int EXT_LVL = 8;
	localparam int EVT_CAP = 4;
	// reset values
	localparam logic [1:0] RST_CTRL = 2'h0;
	localparam logic [7:0] RST_MCTRL = 8'h00;
	localparam logic [1:0] RST_CAPCFG = 2'h0;
	localparam logic [5:0] RST_EXT = 6'h00;
	localparam logic [4:0] RST_IEN = 5'h00;
	// action of a pinned output on its match
	typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} match_act_e;
endpackage : timer_pkg

/* File: core/match_out_if.sv */
// match events and pin levels between the timer core and its output unit
// assumes both ends run on the same clock
interface match_out_if;
	logic [1:0] hit;
	logic [1:0] pwm_high;
	logic [1:0] pwm_en;
	logic [3:0] act;
	logic [1:0] level;
	modport core (output hit, output pwm_high, output pwm_en, output act, input level);
	modport pins (input hit, input pwm_high, input pwm_en, input act, output level);
endinterface : match_out_if

/* File: core/presc_divider.sv */
// prescaler: counts clocks and gives a one-cycle tick at its terminal count
// assumes run and clear come from registers in the same clock domain
module presc_divider #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// control
	input wire logic run,
	input wire logic clear,
	input wire logic [WIDTH-1:0] limit,
	// result
	output logic tick,
	output logic [WIDTH-1:0] value
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	assign tick = run && !clear && (cnt_q == limit);
	assign cnt_d = clear ? '0 : (!run ? cnt_q : (tick ? '0 : cnt_q + WIDTH'(1)));
	assign value = cnt_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	a_presc_wrap: assert property (@(posedge core_clk) disable iff (!nrst) tick |=> cnt_q == '0)
		else $error("prescaler did not restart after tick");
endmodule : presc_divider

/* File: core/match_out_unit.sv */
// pinned match outputs: set, clear, toggle or keep on match, or pwm level
// assumes hit is a one-cycle pulse and pwm_high is the counter-at-or-above-match level
module match_out_unit (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// core side
	match_out_if.pins mo
);
	import timer_pkg::*;
	logic [1:0] lvl_q;
	logic [1:0] lvl_d;

	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < NUM_OUT; i++) begin
			if (mo.pwm_en[i]) begin
				lvl_d[i] = mo.pwm_high[i];
			end else if (mo.hit[i]) begin
				unique case (match_act_e'(mo.act[2*i +: 2]))
					ACT_NONE: lvl_d[i] = lvl_q[i];
					ACT_LOW: lvl_d[i] = 1'b0;
					ACT_HIGH: lvl_d[i] = 1'b1;
					ACT_TOGGLE: lvl_d[i] = !lvl_q[i];
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lvl_q <= '0;
		end else begin
			lvl_q <= lvl_d;
		end
	end
	assign mo.level = lvl_q;

	a_out_toggle: assert property (@(posedge core_clk) disable iff (!nrst)
		(!mo.pwm_en[0] && mo.hit[0] && mo.act[1:0] == 2'h3) |=> lvl_q[0] != $past(lvl_q[0]))
		else $error("output 0 did not toggle on match");
	a_pwm_level: assert property (@(posedge core_clk) disable iff (!nrst)
		mo.pwm_en[1] |=> lvl_q[1] == $past(mo.pwm_high[1]))
		else $error("pwm output 1 does not follow counter level");
endmodule : match_out_unit

/* File: core/match_capture_timer.sv */
// match/capture timer: prescaled counter, four matches, one capture, two pins
// assumes synchronous capture input and a one-cycle strobe register port
// Function
// - The narrow build has a 16-bit counter behind a 16-bit prescaler.
// - The wide build has a 32-bit counter behind a 32-bit prescaler and behaves the same.
// - Four counter-wide match registers flag an equal count and counting goes on.
// - A match can be set to halt the counter, with an optional interrupt.
// - A match can be set to return the counter to zero, with an optional interrupt.
// - Two pinned outputs go low, high, toggle or stay on their match, chosen per output.
// - Matches 0 and 1 can drive their pins as single-edge pwm outputs.
// - Counter and prescaler run on the peripheral clock taken from the system clock.
// - An edge on the capture input latches the count, with an optional interrupt.
//
// Added by the designer: the register addresses and strobed register access.
module match_capture_timer #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// register port
	input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// capture pin
	input wire logic capture_in,
	// match pins
	output logic [timer_pkg::NUM_OUT-1:0] match_out,
	// interrupt
	output logic irq
);
	import timer_pkg::*;

	function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction : sel

	function automatic logic [31:0] ext(input logic [WIDTH-1:0] v);
		logic [31:0] r;
		r = '0;
		r[WIDTH-1:0] = v;
		return r;
	endfunction : ext

	logic [1:0] ctrl_q;
	logic [1:0] ctrl_d;
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	logic [WIDTH-1:0] presc_lim_q;
	logic [WIDTH-1:0] match_q [NUM_MATCH];
	logic [7:0] mctrl_q;
	logic [1:0] capcfg_q;
	logic cap_prev_q;
	logic [WIDTH-1:0] cap_val_q;
	logic [5:0] ext_q;
	logic [NUM_EVT-1:0] stat_q;
	logic [NUM_EVT-1:0] stat_d;
	logic [NUM_EVT-1:0] ien_q;
	logic irq_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// decode
	wire wr_ctrl = reg_wr && sel(reg_addr, OFF_CTRL);
	wire wr_count = reg_wr && sel(reg_addr, OFF_COUNT);
	wire wr_presc = reg_wr && sel(reg_addr, OFF_PRESC);
	wire wr_mctrl = reg_wr && sel(reg_addr, OFF_MCTRL);
	wire wr_capcfg = reg_wr && sel(reg_addr, OFF_CAPCFG);
	wire wr_ext = reg_wr && sel(reg_addr, OFF_EXT);
	wire wr_clr = reg_wr && sel(reg_addr, OFF_CLR);
	wire wr_ien = reg_wr && sel(reg_addr, OFF_IEN);
	wire [7:0] match_off = reg_addr - OFF_MATCH0;
	wire is_match = (match_off < MATCH_SPAN) && (match_off[1:0] == 2'h0);
	wire [1:0] match_idx = match_off[3:2];
	wire wr_match = reg_wr && is_match;

	// prescaler; counter and prescaler held at zero while the hold bit is set
	// lowering the limit below a running prescale count stalls it until it wraps, so set hold first
	wire run = ctrl_q[CTRL_RUN];
	wire hold = ctrl_q[CTRL_HOLD];
	wire tick;
	wire [WIDTH-1:0] presc_val;

	presc_divider #(
		.WIDTH(WIDTH)
	) u_presc (
		.core_clk(core_clk),
		.nrst(nrst),
		.run(run),
		.clear(hold),
		.limit(presc_lim_q),
		.tick(tick),
		.value(presc_val)
	);

	// match detection only on a counting step, so a stopped count does not refire
	logic [NUM_MATCH-1:0] match_hit;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MATCH; gi++) begin : g_hit
			assign match_hit[gi] = tick && (count_q == match_q[gi]);
		end
	endgenerate

	logic [NUM_MATCH-1:0] rst_bits;
	logic [NUM_MATCH-1:0] stop_bits;
	always_comb begin
		for (int i = 0; i < NUM_MATCH; i++) begin
			rst_bits[i] = mctrl_q[2*i];
			stop_bits[i] = mctrl_q[2*i+1];
		end
	end
	wire any_reset = |(match_hit & rst_bits);
	wire any_stop = |(match_hit & stop_bits);

	// counter next value: software write wins, then hold, then match actions
	always_comb begin
		if (wr_count) begin
			count_d = reg_wdata[WIDTH-1:0];
		end else if (hold || any_reset) begin
			count_d = '0;
		end else if (any_stop) begin
			count_d = count_q;
		end else if (tick) begin
			count_d = count_q + WIDTH'(1);
		end else begin
			count_d = count_q;
		end
	end

	// a stop match clears the run bit unless software writes control that cycle
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = reg_wdata[1:0];
		end else if (any_stop) begin
			ctrl_d[CTRL_RUN] = 1'b0;
		end
	end

	// capture edge; capture_in is already synchronous to core_clk
	// the last-sample flop resets low like the idle pin, so reset gives no false rising capture
	wire cap_rise = capcfg_q[CAP_RISE] && capture_in && !cap_prev_q;
	wire cap_fall = capcfg_q[CAP_FALL] && !capture_in && cap_prev_q;
	wire cap_evt = cap_rise || cap_fall;

	// sticky flags: a new event beats a clear in the same cycle
	wire [NUM_EVT-1:0] events = {cap_evt, match_hit};
	wire [NUM_EVT-1:0] clr_mask = wr_clr ? reg_wdata[NUM_EVT-1:0] : '0;
	assign stat_d = (stat_q & ~clr_mask) | events;

	// pinned outputs follow matches 0 and 1; match 3 is meant to set the period
	match_out_if mo_if ();
	assign mo_if.hit = match_hit[1:0];
	assign mo_if.act = ext_q[3:0];
	assign mo_if.pwm_en = ext_q[EXT_PWM +: 2];
	assign mo_if.pwm_high[0] = count_q >= match_q[0];
	assign mo_if.pwm_high[1] = count_q >= match_q[1];

	match_out_unit u_out (
		.core_clk(core_clk),
		.nrst(nrst),
		.mo(mo_if.pins)
	);

	// read mux; unmapped and write-only offsets read as zero
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			if (is_match) begin
				rdata_d = ext(match_q[match_idx]);
			end else begin
				unique case (reg_addr)
					OFF_CTRL: rdata_d = {30'h0, ctrl_q};
					OFF_COUNT: rdata_d = ext(count_q);
					OFF_PRESC: rdata_d = ext(presc_lim_q);
					OFF_PCOUNT: rdata_d = ext(presc_val);
					OFF_MCTRL: rdata_d = {24'h0, mctrl_q};
					OFF_CAPVAL: rdata_d = ext(cap_val_q);
					OFF_CAPCFG: rdata_d = {30'h0, capcfg_q};
					OFF_EXT: rdata_d = {22'h0, mo_if.level, 2'h0, ext_q};
					OFF_STAT: rdata_d = {27'h0, stat_q};
					OFF_IEN: rdata_d = {27'h0, ien_q};
					default: rdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= RST_CTRL;
			count_q <= '0;
			presc_lim_q <= '0;
			mctrl_q <= RST_MCTRL;
			capcfg_q <= RST_CAPCFG;
			ext_q <= RST_EXT;
			ien_q <= RST_IEN;
		end else begin
			ctrl_q <= ctrl_d;
			count_q <= count_d;
			if (wr_presc) begin
				presc_lim_q <= reg_wdata[WIDTH-1:0];
			end
			if (wr_mctrl) begin
				mctrl_q <= reg_wdata[7:0];
			end
			if (wr_capcfg) begin
				capcfg_q <= reg_wdata[1:0];
			end
			if (wr_ext) begin
				ext_q <= reg_wdata[5:0];
			end
			if (wr_ien) begin
				ien_q <= reg_wdata[NUM_EVT-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_MATCH; i++) begin
				match_q[i] <= '0;
			end
		end else if (wr_match) begin
			match_q[match_idx] <= reg_wdata[WIDTH-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cap_prev_q <= 1'b0;
			cap_val_q <= '0;
		end else begin
			cap_prev_q <= capture_in;
			if (cap_evt) begin
				cap_val_q <= count_q;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stat_q <= '0;
			irq_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			stat_q <= stat_d;
			irq_q <= |(stat_q & ien_q);
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign match_out = mo_if.level;

	// counter and prescaler
	a_count_step: assert property (@(posedge core_clk) disable iff (!nrst)
		(tick && !any_reset && !any_stop && !wr_count && !hold)
		|=> count_q == $past(count_q) + WIDTH'(1))
		else $error("counter did not step on prescaler tick");
	a_count_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		(!tick && !wr_count && !hold)
		|=> $stable(count_q))
		else $error("counter moved without a tick");
	a_count_write: assert property (@(posedge core_clk) disable iff (!nrst)
		wr_count
		|=> count_q == $past(reg_wdata[WIDTH-1:0]))
		else $error("counter write did not land");
	a_hold_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		(hold && !wr_count)
		|=> count_q == '0 && presc_val == '0)
		else $error("hold did not zero counter and prescaler");
	a_match_reset: assert property (@(posedge core_clk) disable iff (!nrst)
		(any_reset && !wr_count)
		|=> count_q == '0)
		else $error("reset match did not zero the counter");
	// stop leaves the run bit low, so no tick follows
	a_match_stop: assert property (@(posedge core_clk) disable iff (!nrst)
		(any_stop && !wr_ctrl)
		|=> !run ##1 !tick)
		else $error("stop match did not halt the counter");
	a_stop_keep: assert property (@(posedge core_clk) disable iff (!nrst)
		(any_stop && !any_reset && !wr_count)
		|=> $stable(count_q))
		else $error("stop match moved the counter");
	a_match_write: assert property (@(posedge core_clk) disable iff (!nrst)
		wr_match
		|=> match_q[$past(match_idx)] == $past(reg_wdata[WIDTH-1:0]))
		else $error("match register write did not land");

	// flags, interrupt and capture
	a_match_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		match_hit[3]
		|=> stat_q[3] ##1 (irq_q == ien_q[3] || $past(|(stat_q & ien_q))))
		else $error("match flag or interrupt missing");
	a_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
		(|events)
		|=> (stat_q & $past(events)) == $past(events))
		else $error("event did not set its flag");
	a_flag_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		(wr_clr && events == '0)
		|=> (stat_q & $past(clr_mask)) == '0)
		else $error("clear did not drop the flags");
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
		(stat_q[0] && !wr_clr)
		|=> stat_q[0])
		else $error("flag dropped without a clear");
	a_irq_level: assert property (@(posedge core_clk) disable iff (!nrst)
		irq_q == $past(|(stat_q & ien_q)))
		else $error("interrupt does not follow enabled flags");
	a_irq_masked: assert property (@(posedge core_clk) disable iff (!nrst)
		(ien_q == '0)
		|=> !irq_q)
		else $error("interrupt raised with all enables off");
	a_cap_latch: assert property (@(posedge core_clk) disable iff (!nrst)
		cap_evt
		|=> cap_val_q == $past(count_q) && stat_q[EVT_CAP])
		else $error("capture did not latch count");
	a_cap_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
		!cap_evt
		|=> $stable(cap_val_q))
		else $error("captured value moved without an edge");

	// register port
	a_read_data: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && sel(reg_addr, OFF_STAT))
		|=> reg_rdata == {27'h0, $past(stat_q)})
		else $error("status read returned wrong data");
	a_ext_read: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && sel(reg_addr, OFF_EXT))
		|=> reg_rdata[EXT_LVL +: NUM_OUT] == $past(match_out))
		else $error("pin levels read back wrong");
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		!reg_rd
		|=> reg_rdata == '0)
		else $error("read data not zero outside a read");
endmodule : match_capture_timer

/* File: testbench/capture_source.sv */
// partner model: the signal source on the timer's capture pin
// assumes one clock shared with the timer; the pin follows a bench request
module capture_source #(
	parameter int LAG = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// bench side
	input wire logic level_req,
	// pin
	output logic capture_in
);
	logic [LAG-1:0] pipe_q;
	// a longer lag models a slow source; the pin only moves after a clock edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pipe_q <= '0;
		end else begin
			pipe_q <= LAG'({pipe_q, level_req});
		end
	end
	assign capture_in = pipe_q[LAG-1];
endmodule : capture_source

/* File: testbench/match_capture_timer_test.sv */
// self-checking bench for the narrow match/capture timer
// assumes the register port and pin timing given with the design
module match_capture_timer_test;
	timeunit 1ns;
	timeprecision 1ns;
	import timer_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic capture_in;
	logic cap_req = 1'b0;
	logic [1:0] match_out;
	logic irq;
	logic [31:0] wide_rdata;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	match_act_e acts [4] = '{ACT_HIGH, ACT_LOW, ACT_TOGGLE, ACT_NONE};
	logic lv [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

	always #50 core_clk = ~core_clk;

	match_capture_timer #(.WIDTH(16)) dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.capture_in(capture_in), .match_out(match_out), .irq(irq));
	capture_source #(.LAG(2)) src (.core_clk(core_clk), .nrst(nrst), .level_req(cap_req),
		.capture_in(capture_in));
	// wide build shares the bus; only its counter width is compared
	match_capture_timer #(.WIDTH(32)) dut_wide (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(wide_rdata),
		.capture_in(capture_in), .match_out(), .irq());

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the read edge
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rc

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic wait_irq();
		#1;
		for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
			tick(1);
		end
	endtask : wait_irq

	task automatic edge_gap(output int gap);
		logic prev;
		#1;
		prev = match_out[0];
		gap = 0;
		while (match_out[0] === prev && gap < 100) begin
			tick(1);
			gap++;
		end
	endtask : edge_gap

	task automatic cap(input logic v);
		@(posedge core_clk);
		cap_req <= v;
		tick(5);
	endtask : cap

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			end_sim();
		end
	end

	initial begin
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		for (int a = 0; a < 64; a += 4) begin
			rc(8'(a), 32'h0);
		end
		wr(OFF_STAT, 32'h1f);
		wr(OFF_PCOUNT, 32'h5);
		rc(OFF_STAT, 32'h0);
		rc(OFF_PCOUNT, 32'h0);
		wr(OFF_COUNT, 32'h5);
		wr(OFF_CTRL, 32'h3);
		rc(OFF_COUNT, 32'h0);
		// output actions on pin 1, each run halted by match 1
		wr(OFF_MATCH0, 32'hff);
		wr(OFF_MATCH0 + 8'h04, 32'h3);
		wr(OFF_MCTRL, 32'h8);
		wr(OFF_IEN, 32'h2);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_EXT, {28'h0, acts[i], 2'h0});
			wr(OFF_COUNT, 32'h0);
			wr(OFF_CLR, 32'h1f);
			wr(OFF_CTRL, 32'h1);
			wait_irq();
			chk({31'h0, match_out[1]}, {31'h0, lv[i]});
		end
		chk({31'h0, irq}, 32'h1);
		rc(OFF_COUNT, 32'h3);
		rc(OFF_CTRL, 32'h0);
		rc(OFF_STAT, 32'he);
		rc(OFF_EXT, 32'h200);
		wr(OFF_CLR, 32'h1f);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		// count wraps at the narrow width and halts on a match at zero
		wr(OFF_EXT, 32'h0);
		wr(OFF_MCTRL, 32'h20);
		wr(OFF_MATCH0 + 8'h08, 32'h0);
		wr(OFF_IEN, 32'h4);
		wr(OFF_COUNT, 32'h1ffff);
		rc(OFF_COUNT, 32'hffff);
		chk(wide_rdata, 32'h1ffff);
		wr(OFF_CTRL, 32'h1);
		wait_irq();
		rc(OFF_COUNT, 32'h0);
		rc(OFF_STAT, 32'hc);
		// toggle period is (match + 1) * (prescale + 1) clocks
		wr(OFF_CLR, 32'h1f);
		wr(OFF_EXT, 32'h3);
		wr(OFF_MATCH0, 32'h2);
		wr(OFF_MCTRL, 32'h1);
		wr(OFF_PRESC, 32'h3);
		wr(OFF_COUNT, 32'h0);
		wr(OFF_CTRL, 32'h1);
		edge_gap(n);
		edge_gap(n);
		chk(n, 32'd12);
		// pwm on pin 0: period from unpinned match 3; hold zeroes the prescaler before its limit drops
		wr(OFF_CTRL, 32'h2);
		wr(OFF_PRESC, 32'h0);
		wr(OFF_EXT, 32'h10);
		wr(OFF_MATCH0 + 8'h0c, 32'h5);
		wr(OFF_MCTRL, 32'h40);
		wr(OFF_COUNT, 32'h0);
		wr(OFF_CTRL, 32'h1);
		tick(12);
		n = 0;
		repeat (60) begin
			tick(1);
			if (match_out[0] === 1'b1) n++;
		end
		chk(n, 32'd40);
		// capture on a stopped counter, edge polarity per config
		wr(OFF_CTRL, 32'h0);
		wr(OFF_COUNT, 32'h7);
		wr(OFF_CAPCFG, 32'h1);
		wr(OFF_IEN, 32'h0);
		wr(OFF_CLR, 32'h1f);
		cap(1'b1);
		rc(OFF_CAPVAL, 32'h7);
		rc(OFF_STAT, 32'h10);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_IEN, 32'h10);
		tick(2);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_CLR, 32'h1f);
		wr(OFF_COUNT, 32'h9);
		cap(1'b0);
		rc(OFF_STAT, 32'h0);
		rc(OFF_CAPVAL, 32'h7);
		wr(OFF_CAPCFG, 32'h2);
		cap(1'b1);
		cap(1'b0);
		rc(OFF_CAPVAL, 32'h9);
		rc(OFF_STAT, 32'h10);
		end_sim();
	end
endmodule : match_capture_timer_test
